// [include/psu_sup_cfg.svh]
`ifndef PSU_SUP_CFG_SVH
`define PSU_SUP_CFG_SVH
// Overview of operation
// - supply_good_out rises after good input and 3v3/5v rails hold good 300ms.
// - supply_good_out drops at once when any of those three goes bad.
// - debounced request high forces good output low, and fault output high after the 2.3ms delay.
// - a fault latches the fault output high and keeps good output low.
// - a low-to-high debounced request transition clears the fault latch.
// - reset (supply removal) starts with no fault latched.
// - both request edges are debounced for 38ms.
// - under-voltage fault is blocked while the request falls high to low.
// - 12V under-voltage held over 150us sets the fault latch.
// - over-current on any rail held over 73us sets the fault latch.
// - over-voltage on any rail held over 73us sets the fault latch.
// - good input low with request low: only over-voltage may latch a fault.
// - fault output high means fault latched or rails forced off, low means neither.
// - good output low means fault or not ready, high means good.
// - over-current detection enabled 75ms after request low with good input.
// - at turn-off the fault output rises 2.3ms after the debounced request.

`define CLK_HZ          20000000
`define T_GOOD_MS       300
`define T_DEB_MS        38
`define T_OCEN_MS       75
`define T_OFF_US        2300
`define T_UV12_US       150
`define T_OCOV_US       73
// least times round up to whole cycles
`define CYC_US(u)       (((u) * (`CLK_HZ / 1000000)))
`define CYC_GOOD        (`T_GOOD_MS * 1000 * (`CLK_HZ / 1000000))
`define CYC_DEB         (`T_DEB_MS * 1000 * (`CLK_HZ / 1000000))
`define CYC_OCEN        (`T_OCEN_MS * 1000 * (`CLK_HZ / 1000000))
`define CYC_OFF         `CYC_US(`T_OFF_US)
`define CYC_UV12        (`CYC_US(`T_UV12_US) + 1)
`define CYC_OCOV        (`CYC_US(`T_OCOV_US) + 1)
`define TMR_W           24
`define FILT_W          12
`endif

// [include/psu_sup_pkg.sv]
package psu_sup_pkg;
  typedef logic [23:0] tmr_t;
  typedef enum logic [1:0] {
    st_off,
    st_turn_on,
    st_on,
    st_turn_off
  } req_st_e;
endpackage

// [rtl/sync2.sv]
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s st_ff;
  sync_s nxt_st;
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q = st_ff.s2;
endmodule

// [rtl/hold_timer.sv]
// output rises once cond has stood CYCLES cycles; restarts when cond drops
module hold_timer #(
  parameter int unsigned W      = 24,
  parameter int unsigned CYCLES = 1
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic cond,
  output logic      done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } tmr_s;
  tmr_s st_ff;
  tmr_s nxt_st;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  always_comb begin
    nxt_st = st_ff;
    if (!cond) begin
      nxt_st.cnt  = '0;
      nxt_st.done = 1'b0;
    end else if (st_ff.cnt == LAST) begin
      nxt_st.done = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + W'(1);
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign done = st_ff.done & cond;
endmodule

// [rtl/psu_supervisor.sv]
`include "psu_sup_cfg.svh"
module psu_supervisor #(
  parameter int unsigned GOOD_CYC = `CYC_GOOD,
  parameter int unsigned DEB_CYC  = `CYC_DEB,
  parameter int unsigned OCEN_CYC = `CYC_OCEN,
  parameter int unsigned OFF_CYC  = `CYC_OFF,
  parameter int unsigned UV12_CYC = `CYC_UV12,
  parameter int unsigned OCOV_CYC = `CYC_OCOV
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // motherboard request, low turns rails on
  input  wire logic       rails_on_request_n,
  // compared conditions
  input  wire logic       supply_good_in,
  input  wire logic       rail3v3_sense,
  input  wire logic       rail5v_sense,
  input  wire logic       undervoltage_guard,
  input  wire logic [2:0] overvoltage_guard,
  input  wire logic [2:0] overcurrent_guard,
  // outputs
  output logic            fault_shutdown_out,
  output logic            supply_good_out
);
  import psu_sup_pkg::*;

  typedef struct packed {
    req_st_e    req_st;
    logic [`TMR_W-1:0] cnt;
    logic       req_deb;
    logic       fault;
    logic       off_force;
    logic       good;
  } core_s;

  core_s st_ff;
  core_s nxt_st;

  logic       req_s;
  logic       good_in_s;
  logic       r33_s;
  logic       r5_s;
  logic       uv12_s;
  logic [2:0] ov_s;
  logic [2:0] oc_s;
  logic       rails_ok;
  logic       good_done;
  logic       uv12_done;
  logic       ov_done;
  logic       oc_done;
  logic       ocen_done;

  // every pin passes two flops first
  sync2 #(.W(11)) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({rails_on_request_n, supply_good_in, rail3v3_sense,
             rail5v_sense, undervoltage_guard, overvoltage_guard,
             overcurrent_guard}),
    .q     ({req_s, good_in_s, r33_s, r5_s, uv12_s, ov_s, oc_s})
  );
  assign rails_ok = good_in_s & r33_s & r5_s;

  // power-good delay, restarts on any drop
  hold_timer #(.W(`TMR_W), .CYCLES(GOOD_CYC)) u_good (
    .clock (clock),
    .rst   (rst),
    .cond  (rails_ok & ~st_ff.req_deb & ~st_ff.fault),
    .done  (good_done)
  );

  // 12V under-voltage deglitch, blocked during turn-on ramp
  hold_timer #(.W(`TMR_W), .CYCLES(UV12_CYC)) u_uv12 (
    .clock (clock),
    .rst   (rst),
    .cond  (uv12_s & good_in_s & (st_ff.req_st == st_on)),
    .done  (uv12_done)
  );

  hold_timer #(.W(`TMR_W), .CYCLES(OCOV_CYC)) u_ov (
    .clock (clock),
    .rst   (rst),
    .cond  (|ov_s),
    .done  (ov_done)
  );

  hold_timer #(.W(`TMR_W), .CYCLES(OCOV_CYC)) u_oc (
    .clock (clock),
    .rst   (rst),
    .cond  ((|oc_s) & good_in_s & ocen_done),
    .done  (oc_done)
  );

  // over-current enable after request low with good input
  hold_timer #(.W(`TMR_W), .CYCLES(OCEN_CYC)) u_ocen (
    .clock (clock),
    .rst   (rst),
    .cond  (~st_ff.req_deb & good_in_s),
    .done  (ocen_done)
  );

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.req_st)
      st_off: begin
        if (!req_s) begin
          nxt_st.req_st = st_turn_on;
          nxt_st.cnt    = '0;
        end
      end
      st_turn_on: begin
        if (req_s) begin
          nxt_st.req_st = st_off;
        end else if (st_ff.cnt == `TMR_W'(DEB_CYC - 1)) begin
          nxt_st.req_st  = st_on;
          nxt_st.req_deb = 1'b0;
          nxt_st.off_force = 1'b0;
        end else begin
          nxt_st.cnt = st_ff.cnt + `TMR_W'(1);
        end
      end
      st_on: begin
        if (req_s) begin
          nxt_st.req_st = st_turn_off;
          nxt_st.cnt    = '0;
        end
      end
      st_turn_off: begin
        if (!req_s) begin
          nxt_st.req_st = st_on;
        end else if (st_ff.cnt == `TMR_W'(DEB_CYC - 1)) begin
          nxt_st.req_st  = st_off;
          nxt_st.req_deb = 1'b1;
          nxt_st.fault   = 1'b0;
          // latched fault hands over to off-force with no low gap
          nxt_st.off_force = st_ff.fault;
        end else begin
          nxt_st.cnt = st_ff.cnt + `TMR_W'(1);
        end
      end
    endcase
    // turn-off delay after debounced high
    if (st_ff.req_st == st_off && st_ff.req_deb && !st_ff.off_force &&
        req_s) begin
      if (st_ff.cnt == `TMR_W'(DEB_CYC - 1 + OFF_CYC)) begin
        nxt_st.off_force = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + `TMR_W'(1);
      end
    end
    // faults latch; set wins over the clear
    if (!st_ff.req_deb && (ov_done || oc_done || uv12_done)) begin
      nxt_st.fault = 1'b1;
    end
    // good output drops at once, rises after delay
    nxt_st.good = good_done & rails_ok & ~nxt_st.fault & ~nxt_st.req_deb;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= '{req_st: st_off, cnt: '0, req_deb: 1'b1, fault: 1'b0,
                 off_force: 1'b1, good: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fault_shutdown_out = st_ff.fault | st_ff.off_force;
  assign supply_good_out = st_ff.good & rails_ok;
endmodule

// [verification/psu_supervisor_sva.sv]
module psu_supervisor_sva #(
  parameter int unsigned GOOD_CYC = 40,
  parameter int unsigned DEB_CYC  = 20,
  parameter int unsigned OFF_CYC  = 10,
  parameter int unsigned OCOV_CYC = 4
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       rails_on_request_n,
  input wire logic       supply_good_in,
  input wire logic       rail3v3_sense,
  input wire logic       rail5v_sense,
  input wire logic [2:0] overvoltage_guard,
  input wire logic       fault_shutdown_out,
  input wire logic       supply_good_out
);
  timeunit 1ns;
  timeprecision 1ns;
  wire ok = supply_good_in && rail3v3_sense && rail5v_sense;
  logic [15:0] ok_ff, lo_ff, hi_ff, ov_ff;
  // run lengths of each input condition
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ok_ff <= 16'h0000;
      lo_ff <= 16'h0000;
      hi_ff <= 16'h0000;
      ov_ff <= 16'h0000;
    end else begin
      ok_ff <= ok ? ok_ff + 16'h0001 : 16'h0000;
      lo_ff <= !rails_on_request_n ? lo_ff + 16'h0001 : 16'h0000;
      hi_ff <= rails_on_request_n ? hi_ff + 16'h0001 : 16'h0000;
      ov_ff <= |overvoltage_guard ? ov_ff + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_ov_held; ov_ff == OCOV_CYC + 4; endsequence
  sequence s_shut; ##[0:4] fault_shutdown_out; endsequence
  property p_init; $fell(rst) |-> fault_shutdown_out && !supply_good_out;
  endproperty
  property p_ov; s_ov_held |-> s_shut; endproperty
  property p_drop; $fell(ok) |-> ##[1:5] !supply_good_out; endproperty
  property p_rise; $rose(supply_good_out) |-> ok_ff >= GOOD_CYC; endproperty
  property p_deb; $fell(fault_shutdown_out) |-> lo_ff >= DEB_CYC; endproperty
  property p_off;
    hi_ff == DEB_CYC + OFF_CYC + 6 |-> fault_shutdown_out && !supply_good_out;
  endproperty
  property p_latch;
    fault_shutdown_out && lo_ff > DEB_CYC + 6 |=> fault_shutdown_out;
  endproperty
  property p_pg; fault_shutdown_out [*3] |-> !supply_good_out; endproperty
  a_init: assert property (p_init) else $error("bad state after reset");
  a_ov: assert property (p_ov) else $error("over-voltage not latched");
  a_drop: assert property (p_drop) else $error("good output late low");
  a_rise: assert property (p_rise) else $error("good output early");
  a_deb: assert property (p_deb) else $error("request not debounced");
  a_off: assert property (p_off) else $error("off request ignored");
  a_latch: assert property (p_latch) else $error("fault not held");
  a_pg: assert property (p_pg) else $error("good high in fault");
endmodule

// [verification/psu_rail_model.sv]
// motherboard request and main converter rails
module psu_rail_model (
  input  wire logic clock,
  input  wire logic want_on,
  input  wire logic pgi_en,
  input  wire logic drop5,
  input  wire logic fault_shutdown_out,
  output logic      rails_on_request_n,
  output logic      supply_good_in,
  output logic      rail3v3_sense,
  output logic      rail5v_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ramp;
  initial begin
    {rails_on_request_n, supply_good_in} = 2'h2;
    {rail3v3_sense, rail5v_sense, ramp} = 4'h0;
  end
  // rails ramp while fault output low, collapse when high
  always @(posedge clock) begin
    rails_on_request_n <= !want_on;
    ramp <= fault_shutdown_out ? 2'h0 : ramp + {1'b0, ramp != 2'h3};
    rail3v3_sense <= ramp == 2'h3;
    rail5v_sense <= ramp == 2'h3 && !drop5;
    supply_good_in <= ramp == 2'h3 && pgi_en;
  end
endmodule

// [verification/test_psu_supervisor.sv]
module test_psu_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GOOD = 40, DEB = 20, OFF = 10;
  logic clock = 1'b0, rst = 1'b1, want_on = 1'b0;
  logic pgi_en = 1'b1, drop5 = 1'b0;
  logic [6:0] cond = 7'h00;
  logic rails_on_request_n, supply_good_in, rail3v3_sense, rail5v_sense;
  logic fault_shutdown_out, supply_good_out;
  int fail_count = 0, comparisons = 0;
  always #25 clock = ~clock;
  psu_supervisor #(.GOOD_CYC(GOOD), .DEB_CYC(DEB), .OCEN_CYC(30),
    .OFF_CYC(OFF), .UV12_CYC(5), .OCOV_CYC(4)) u_psu_supervisor (
    .clock, .rst, .rails_on_request_n, .supply_good_in, .rail3v3_sense,
    .rail5v_sense, .undervoltage_guard(cond[6]),
    .overcurrent_guard(cond[5:3]), .overvoltage_guard(cond[2:0]),
    .fault_shutdown_out, .supply_good_out);
  psu_rail_model u_psu_rail_model (.clock, .want_on, .pgi_en, .drop5,
    .fault_shutdown_out, .rails_on_request_n, .supply_good_in,
    .rail3v3_sense, .rail5v_sense);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic t_on();
    want_on <= 1'b1;
    tick(DEB - 1);
    chk(fault_shutdown_out, 1'b1);
    tick(8);
    chk(fault_shutdown_out, 1'b0);
    tick(GOOD - 4);
    chk(supply_good_out, 1'b0);
    tick(GOOD);
    chk(supply_good_out, 1'b1);
    $display("turn-on done");
  endtask
  task automatic t_glitch();
    want_on <= 1'b0;
    tick(DEB / 2);
    want_on <= 1'b1;
    tick(DEB + OFF + 8);
    chk(fault_shutdown_out, 1'b0);
    $display("glitch done");
  endtask
  task automatic t_drop();
    drop5 <= 1'b1;
    tick(7);
    chk(supply_good_out, 1'b0);
    drop5 <= 1'b0;
    pgi_en <= 1'b0;
    cond <= 7'h48;
    tick(30);
    chk(fault_shutdown_out, 1'b0);
    cond <= 7'h00;
    pgi_en <= 1'b1;
    tick(GOOD + 10);
    chk(supply_good_out, 1'b1);
    $display("drop done");
  endtask
  task automatic t_trip(input logic [6:0] v);
    cond <= v;
    tick(2);
    cond <= 7'h00;
    tick(20);
    chk(fault_shutdown_out, 1'b0);
    cond <= v;
    tick(12);
    cond <= 7'h00;
    tick(30);
    chk({fault_shutdown_out, supply_good_out}, 2'h2);
    want_on <= 1'b0;
    tick(DEB + OFF + 10);
    chk(fault_shutdown_out, 1'b1);
    t_on();
    $display("trip done");
  endtask
  task automatic t_off();
    want_on <= 1'b0;
    tick(DEB + 5);
    chk(fault_shutdown_out, 1'b0);
    tick(OFF + 3);
    chk({fault_shutdown_out, supply_good_out}, 2'h2);
    t_on();
    $display("turn-off done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(20);
    rst <= 1'b0;
    t_on();
    t_glitch();
    t_off();
    t_drop();
    for (int i = 0; i < 7; i++) t_trip(7'h01 << i);
    end_sim();
  end
  initial begin
    tick(8000);
    fail_count++;
    end_sim();
  end
endmodule
bind psu_supervisor psu_supervisor_sva #(.GOOD_CYC(GOOD_CYC),
  .DEB_CYC(DEB_CYC), .OFF_CYC(OFF_CYC), .OCOV_CYC(OCOV_CYC))
  u_psu_supervisor_sva (.clock, .rst, .rails_on_request_n,
  .supply_good_in, .rail3v3_sense, .rail5v_sense, .overvoltage_guard,
  .fault_shutdown_out, .supply_good_out);
